//--- inc/vsidec_pkg.sv
// vsidec_pkg: register map, field layout and reset values of the slave image decoder.
// assumes a 32-bit AHB-Lite register bus and three slave images (0, 1 and 2).
package vsidec_pkg;
    // number of decoded slave images
    localparam int NUM_IMG = 3;
    // register byte addresses, one entry per image
    localparam logic [31:0] CTL_OFS [NUM_IMG] = '{32'h0000_0F00, 32'h0000_0F14, 32'h0000_0F28};
    localparam logic [31:0] BASE_OFS [NUM_IMG] = '{32'h0000_0F04, 32'h0000_0F18, 32'h0000_0F2C};
    localparam logic [31:0] BOUND_OFS [NUM_IMG] = '{32'h0000_0F08, 32'h0000_0F1C, 32'h0000_0F30};
    localparam logic [31:0] OFFS_OFS [NUM_IMG] = '{32'h0000_0F0C, 32'h0000_0F20, 32'h0000_0F34};
    // command/status word holding the pci master enable
    localparam logic [31:0] CSR_OFS = 32'h0000_0004;
    // decoder status word
    localparam logic [31:0] STAT_OFS = 32'h0000_0F80;
    // control field positions; BM_BIT is the master enable bit of the command/status word
    localparam int EN_BIT = 31;
    localparam int PW_BIT = 30;
    localparam int PR_BIT = 29;
    localparam int PGM_LSB = 22;
    localparam int SUP_LSB = 20;
    localparam int VAS_LSB = 16;
    localparam int WIDE_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int LAS_LSB = 0;
    localparam int BM_BIT = 2;
    // writable control bits; reserved bits read as zero
    localparam logic [31:0] CTL_MASK = 32'hE0F7_00C3;
    localparam logic [31:0] CSR_MASK = 32'h0000_0004;
    // control reset values: program/data and privilege both "both"
    localparam logic [31:0] CTL_RST [NUM_IMG] = '{32'h00F0_0000, 32'h00F0_00C0, 32'h00F0_0000};
    // window granularity: 4 KB for image 0, 64 KB for the others
    localparam logic [31:0] GRAN_MASK [NUM_IMG] = '{32'hFFFF_F000, 32'hFFFF_0000, 32'hFFFF_0000};
    localparam logic [31:0] ZERO_W = 32'h0000_0000;
    // vme space selector codes
    localparam logic [2:0] VAS_A16 = 3'h0;
    localparam logic [2:0] VAS_A24 = 3'h1;
    localparam logic [2:0] VAS_A32 = 3'h2;
    localparam logic [2:0] VAS_USER1 = 3'h6;
    localparam logic [2:0] VAS_USER2 = 3'h7;
    // pci space selector codes
    localparam logic [1:0] LAS_MEM = 2'h0;
    localparam logic [1:0] LAS_IO = 2'h1;
    localparam logic [1:0] LAS_CFG = 2'h2;
    // queue depth and entry width
    localparam int QDEPTH = 8;
    localparam int QLVL_W = 4;
    localparam int ENTRY_W = 73;
    // status field positions
    localparam int ST_HIT_LSB = 8;
    localparam int ST_HITV_BIT = 12;
    localparam int ST_MISS_BIT = 16;
endpackage

//--- core/vsidec_fifo.sv
// vsidec_fifo: small synchronous queue with valid/ready on both sides.
// assumes one clock; head word is held in a register.
`timescale 1ns/1ps
`default_nettype none
module vsidec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int LVL_W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [LVL_W-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage
    logic [PW-1:0] wr_q; // write pointer
    logic [PW-1:0] rd_q; // read pointer
    logic [PW-1:0] rd_d; // read pointer after this cycle
    logic [LVL_W-1:0] cnt_q; // entries held
    logic push;
    logic pop;

    // full only refuses when truly full; no lookahead on pop keeps the path short
    assign in_ready = (cnt_q != LVL_W'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign level = cnt_q;
    assign rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= PW'(wr_q + 1'b1);
            end
            rd_q <= rd_d;
            cnt_q <= LVL_W'(cnt_q + push - pop);
        end
    end

    // registered head; bypass when the new word becomes the head at once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_data <= '0;
        end else if (push && (cnt_q == LVL_W'(pop))) begin
            out_data <= in_data;
        end else begin
            out_data <= mem_q[rd_d];
        end
    end
endmodule
`default_nettype wire

//--- core/vsidec_top.sv
// vsidec_top: vme slave image decoder and translator toward a pci request queue.
// assumes vme cycle attributes arrive pre-decoded and synchronous to clk,
// and an AHB-Lite master as the only master of the register port.
`timescale 1ns/1ps
`default_nettype none
module vsidec_top
    import vsidec_pkg::*;
#(
    parameter int QUEUE_DEPTH = QDEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // ahb-lite register port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // incoming vme cycle
    input wire logic vme_valid,
    output logic vme_ready,
    output logic vme_claim,
    input wire logic [31:0] vme_addr,
    input wire logic [2:0] vme_space,
    input wire logic vme_program,
    input wire logic vme_super,
    input wire logic vme_write,
    input wire logic vme_rmw,
    input wire logic [31:0] vme_wdata,
    // outgoing pci request
    output logic pci_valid,
    input wire logic pci_ready,
    output logic [31:0] pci_addr,
    output logic [31:0] pci_wdata,
    output logic pci_write,
    output logic [1:0] pci_space,
    output logic pci_posted,
    output logic pci_prefetch,
    output logic pci_wide,
    output logic pci_lock,
    output logic [1:0] pci_image
);
    // image registers
    logic [31:0] ctl_q [NUM_IMG]; // control words
    logic [31:0] base_q [NUM_IMG]; // window base
    logic [31:0] bound_q [NUM_IMG]; // window limit
    logic [31:0] offs_q [NUM_IMG]; // translation offset
    logic pci_master_enable_q; // command/status master enable
    // bus data-phase state
    logic wr_q; // write pending in data phase
    logic [31:0] waddr_q; // address of that write
    logic [31:0] rdata_q; // read data for the data phase
    logic [31:0] rdata_d;
    // decode results
    logic hit; // some image claims the cycle
    logic [1:0] hit_idx; // lowest claiming image
    logic [ENTRY_W-1:0] entry; // queue word for the claimed cycle
    logic q_in_ready;
    logic [QLVL_W-1:0] q_level;
    logic [ENTRY_W-1:0] q_out;
    // status
    logic [1:0] last_hit_q; // image of the last claimed cycle
    logic last_hit_v_q; // a claim has happened
    logic miss_q; // a cycle went unclaimed

    // space selector check; A16 only for image 0, reserved codes never match
    function automatic logic space_ok(input int img, input logic [2:0] vme_space_select,
                                      input logic [2:0] sp);
        logic legal;
        legal = 1'b0;
        case (vme_space_select)
            VAS_A16: legal = (img == 0);
            VAS_A24, VAS_A32, VAS_USER1, VAS_USER2: legal = 1'b1;
            default: legal = 1'b0;
        endcase
        return legal && (vme_space_select == sp);
    endfunction

    // two-bit attribute selector: bit1 allows the set case, bit0 the clear case
    function automatic logic sel_ok(input logic [1:0] sel, input logic attr);
        return attr ? sel[1] : sel[0];
    endfunction

    // register read view; unmapped words read as zero
    function automatic logic [31:0] read_word(input logic [31:0] a);
        logic [31:0] v;
        v = ZERO_W;
        for (int i = 0; i < NUM_IMG; i++) begin
            if (a == CTL_OFS[i]) v = ctl_q[i];
            if (a == BASE_OFS[i]) v = base_q[i];
            if (a == BOUND_OFS[i]) v = bound_q[i];
            if (a == OFFS_OFS[i]) v = offs_q[i];
        end
        if (a == CSR_OFS) v = 32'(pci_master_enable_q) << BM_BIT;
        if (a == STAT_OFS) begin
            v = 32'(q_level);
            v[ST_HIT_LSB +: 2] = last_hit_q;
            v[ST_HITV_BIT] = last_hit_v_q;
            v[ST_MISS_BIT] = miss_q;
        end
        return v;
    endfunction

    // the slave never stretches a transfer and always answers okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign rdata_d = read_word(haddr);

    // address phase capture; read data fetched here so it is ready next cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            waddr_q <= ZERO_W;
            rdata_q <= ZERO_W;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            waddr_q <= haddr;
            if (hsel && htrans[1] && !hwrite) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // image register writes; granularity masks clear reserved low bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_IMG; i++) begin
                ctl_q[i] <= CTL_RST[i];
                base_q[i] <= ZERO_W;
                bound_q[i] <= ZERO_W;
                offs_q[i] <= ZERO_W;
            end
        end else if (wr_q) begin
            for (int i = 0; i < NUM_IMG; i++) begin
                if (waddr_q == CTL_OFS[i]) begin
                    ctl_q[i] <= hwdata & CTL_MASK;
                end
                if (waddr_q == BASE_OFS[i]) begin
                    base_q[i] <= hwdata & GRAN_MASK[i];
                end
                if (waddr_q == BOUND_OFS[i]) begin
                    bound_q[i] <= hwdata & GRAN_MASK[i];
                end
                if (waddr_q == OFFS_OFS[i]) begin
                    offs_q[i] <= hwdata & GRAN_MASK[i];
                end
            end
        end
    end

    // pci command/status master enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pci_master_enable_q <= 1'b0;
        end else if (wr_q && (waddr_q == CSR_OFS)) begin
            pci_master_enable_q <= hwdata[BM_BIT];
        end
    end

    // decode: lowest-numbered matching image wins if windows overlap
    always_comb begin
        logic cand;
        logic [31:0] c;
        cand = 1'b0;
        c = ZERO_W;
        hit = 1'b0;
        hit_idx = 2'h0;
        for (int i = 0; i < NUM_IMG; i++) begin
            c = ctl_q[i];
            cand = c[EN_BIT]
                && pci_master_enable_q
                && (vme_addr >= base_q[i]) && (vme_addr < bound_q[i])
                && space_ok(i, c[VAS_LSB +: 3], vme_space)
                && sel_ok(c[PGM_LSB +: 2], vme_program)
                && sel_ok(c[SUP_LSB +: 2], vme_super)
                && (c[LAS_LSB +: 2] != 2'h3);
            if (cand && !hit) begin
                hit = 1'b1;
                hit_idx = 2'(i);
            end
        end
    end

    // build the queue word for the claimed image
    always_comb begin
        logic [31:0] c;
        logic mem;
        c = ctl_q[hit_idx];
        mem = (c[LAS_LSB +: 2] == LAS_MEM);
        entry = {
            vme_addr + offs_q[hit_idx],
            vme_wdata,
            vme_write,
            c[LAS_LSB +: 2],
            vme_write && mem && c[PW_BIT],
            !vme_write && mem && c[PR_BIT],
            c[WIDE_BIT],
            vme_rmw && c[LOCK_BIT],
            hit_idx
        };
    end

    // unclaimed cycles pass at once; claimed ones wait for queue space
    assign vme_claim = vme_valid && hit;
    assign vme_ready = !hit || q_in_ready;

    // request queue toward the pci master
    vsidec_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(QUEUE_DEPTH),
        .LVL_W(QLVL_W)
    ) u_queue (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(vme_claim),
        .in_ready(q_in_ready),
        .in_data(entry),
        .out_valid(pci_valid),
        .out_ready(pci_ready),
        .out_data(q_out),
        .level(q_level)
    );

    // unpack the head word
    assign {pci_addr, pci_wdata, pci_write, pci_space, pci_posted,
            pci_prefetch, pci_wide, pci_lock, pci_image} = q_out;

    // status: last claim and a sticky miss flag cleared by writing the status word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_hit_q <= 2'h0;
            last_hit_v_q <= 1'b0;
            miss_q <= 1'b0;
        end else begin
            if (vme_claim && q_in_ready) begin
                last_hit_q <= hit_idx;
                last_hit_v_q <= 1'b1;
            end
            // a new miss wins over a clear in the same cycle
            if (vme_valid && !hit) begin
                miss_q <= 1'b1;
            end else if (wr_q && (waddr_q == STAT_OFS)) begin
                miss_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/vsidec_top_props.sv
// vsidec_props: port-level checks of the slave image decoder.
// assumes it is bound to vsidec_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module vsidec_props
    import vsidec_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // vme side
    input wire logic vme_valid,
    input wire logic vme_ready,
    input wire logic vme_claim,
    input wire logic [2:0] vme_space,
    input wire logic vme_write,
    input wire logic [31:0] vme_wdata,
    // pci side
    input wire logic [31:0] pci_wdata,
    input wire logic pci_valid,
    input wire logic pci_write,
    input wire logic [1:0] pci_space,
    input wire logic pci_posted,
    input wire logic pci_prefetch,
    input wire logic [1:0] pci_image
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // a claimed cycle taken into an empty queue
    sequence push_s;
        vme_valid && vme_ready && vme_claim && !pci_valid;
    endsequence
    // the same, for an a16 cycle
    sequence short_s;
        push_s ##0 vme_space == VAS_A16;
    endsequence
    reset_no_claim_a: assert property ($rose(rst_b) |-> !vme_claim)
        else $error("claim right after reset");
    attr_ignore_a: assert property (
        pci_valid && pci_space != LAS_MEM |-> !pci_posted && !pci_prefetch)
        else $error("posted or prefetch outside memory space");
    posted_kind_a: assert property (
        pci_valid && pci_posted |-> pci_write && pci_space == LAS_MEM)
        else $error("posted request is not a memory write");
    prefetch_read_a: assert property (pci_valid && pci_prefetch |-> !pci_write)
        else $error("prefetch on a write");
    pci_space_a: assert property (pci_valid |-> pci_space != 2'h3)
        else $error("reserved pci space");
    space_reserved_a: assert property (
        vme_valid && vme_space inside {3'h3, 3'h4, 3'h5} |-> !vme_claim)
        else $error("reserved vme space claimed");
    short_image0_a: assert property (short_s |=> pci_valid && pci_image == 2'h0)
        else $error("a16 cycle not from image 0");
    push_kind_a: assert property (push_s |=> pci_valid && pci_write == $past(vme_write))
        else $error("queued request lost its direction");
    push_data_a: assert property (push_s |=> pci_wdata == $past(vme_wdata))
        else $error("queued request lost its write data");
endmodule
bind vsidec_top vsidec_props u_props (.clk(clk), .rst_b(rst_b), .vme_valid(vme_valid),
    .vme_ready(vme_ready), .vme_claim(vme_claim), .vme_space(vme_space),
    .vme_write(vme_write), .vme_wdata(vme_wdata), .pci_wdata(pci_wdata),
    .pci_valid(pci_valid), .pci_write(pci_write),
    .pci_space(pci_space), .pci_posted(pci_posted), .pci_prefetch(pci_prefetch),
    .pci_image(pci_image));
`default_nettype wire

//--- verification/vsidec_pci_sink.sv
// vsidec_pci_sink: pci target model that drains the request queue.
// assumes valid/ready on clk; mode 0 prompt, 1 every other cycle, 2 stalled.
`timescale 1ns/1ps
`default_nettype none
module vsidec_pci_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pacing
    input wire logic [1:0] mode,
    // request stream
    input wire logic pci_valid,
    output logic pci_ready,
    input wire logic [40:0] req
);
    logic [40:0] got [$]; // accepted requests in order
    logic tick_q; // slow-mode phase
    // ready changes just after each edge, never mid-cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pci_ready <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            if (pci_valid && pci_ready) begin
                got.push_back(req);
            end
            tick_q <= !tick_q;
            pci_ready <= (mode == 2'h0) || (mode == 2'h1 && tick_q);
        end
    end
endmodule
`default_nettype wire

//--- verification/test_vme_slave_image_decode.sv
// test_vme_slave_image_decode: self-checking bench of the slave image decoder.
// assumes the decoder, its queue, checker and pci sink model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_vme_slave_image_decode
    import vsidec_pkg::*;
;
    typedef struct packed {logic [31:0] a; logic [2:0] sp; logic [3:0] am; logic c;
        logic [40:0] e;} vsidec_row_t; // am is program, super, write, rmw
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [1:0] htrans = 2'h0, mode = 2'h0, pci_space, pci_image;
    logic [2:0] hsize = 3'h2, vme_space = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, a, vme_addr = 32'h0;
    logic [31:0] vme_wdata = 32'h0, pci_addr, pci_wdata;
    logic vme_valid = 1'b0, vme_ready, vme_claim, vme_program = 1'b0, vme_super = 1'b0;
    logic vme_write = 1'b0, vme_rmw = 1'b0, pci_valid, pci_ready, pci_write, pci_posted;
    logic pci_prefetch, pci_wide, pci_lock;
    int failures = 0, n_compared = 0;
    logic [40:0] exp_q [$];
    vsidec_row_t r;
    // window edges, attribute filters and reserved spaces
    vsidec_row_t rows [11] = '{'{32'h1000_0000, 3'h2, 4'h2, 1'b1, 41'h09A_0000_0000},
        '{32'h1FFF_FFFC, 3'h2, 4'h5, 1'b1, 41'h087_0FFF_FFFC},
        '{32'h2000_0000, 3'h2, 4'h2, 1'b0, 41'h0}, '{32'h0FFF_FFFC, 3'h2, 4'h2, 1'b0, 41'h0},
        '{32'h0000_8000, 3'h1, 4'h6, 1'b1, 41'h130_0002_8000},
        '{32'h0000_8000, 3'h1, 4'hE, 1'b0, 41'h0}, '{32'h0000_8000, 3'h1, 4'h2, 1'b0, 41'h0},
        '{32'h0000_1800, 3'h0, 4'h0, 1'b1, 41'h040_0000_4800},
        '{32'h0000_2000, 3'h0, 4'h0, 1'b0, 41'h0}, '{32'h1000_0000, 3'h3, 4'h2, 1'b0, 41'h0},
        '{32'h1000_0000, 3'h0, 4'h2, 1'b0, 41'h0}};
    // address/data pairs: master enable, then images 1, 2 and 0
    logic [31:0] cfg [22] = '{CSR_OFS, 32'h0000_0004, CTL_OFS[1], 32'hE0F2_00C0,
        BASE_OFS[1], 32'h1000_0000, BOUND_OFS[1], 32'h2000_0000, OFFS_OFS[1], 32'hF000_0000,
        CTL_OFS[2], 32'hC061_0001, BOUND_OFS[2], 32'h0001_0000, OFFS_OFS[2], 32'h0002_0000,
        CTL_OFS[0], 32'hA0F0_0002, BOUND_OFS[0], 32'h0000_2000, OFFS_OFS[0], 32'h0000_3000};
    assign hready = hreadyout; // single slave
    always #5 clk = !clk;
    vsidec_top dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .vme_valid, .vme_ready, .vme_claim, .vme_addr, .vme_space,
        .vme_program, .vme_super, .vme_write, .vme_rmw, .vme_wdata, .pci_valid, .pci_ready,
        .pci_addr, .pci_wdata, .pci_write, .pci_space, .pci_posted, .pci_prefetch, .pci_wide,
        .pci_lock, .pci_image);
    vsidec_pci_sink sink (.clk, .rst_b, .mode, .pci_valid, .pci_ready, .req({pci_image,
        pci_space, pci_write, pci_posted, pci_prefetch, pci_wide, pci_lock, pci_addr}));
    task automatic check(input string what, input logic [40:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single word transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [31:0] ad, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // offer one vme cycle, hold it until taken
    task automatic vme(input vsidec_row_t v);
        vme_valid <= 1'b1;
        vme_addr <= v.a;
        vme_space <= v.sp;
        {vme_program, vme_super, vme_write, vme_rmw} <= v.am;
        vme_wdata <= ~v.a;
        @(negedge clk);
        check("claim", vme_claim, v.c);
        if (v.c) exp_q.push_back(v.e);
        do @(posedge clk); while (vme_ready !== 1'b1);
        vme_valid <= 1'b0;
        @(posedge clk);
    endtask
    // wait until the sink has all, then compare in order
    task automatic drain();
        repeat (2) @(posedge clk);
        while (pci_valid) @(posedge clk);
        check("count", sink.got.size(), exp_q.size());
        foreach (exp_q[i]) check("entry", sink.got[i], exp_q[i]);
        exp_q.delete();
        sink.got.delete();
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // a hang is cut short well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial begin
        do_reset();
        // reset values, then writable fields through all ones
        for (int k = 0; k < 4 * NUM_IMG; k++) begin
            a = k % 4 == 0 ? CTL_OFS[k / 4] : k % 4 == 1 ? BASE_OFS[k / 4] :
                k % 4 == 2 ? BOUND_OFS[k / 4] : OFFS_OFS[k / 4];
            xfer(1'b0, a, 32'h0);
            check("reset", rd, k % 4 == 0 ? CTL_RST[k / 4] : 32'h0);
            xfer(1'b1, a, 32'hFFFF_FFFF);
            xfer(1'b0, a, 32'h0);
            check("field", rd, k % 4 == 0 ? CTL_MASK : GRAN_MASK[k / 4]);
        end
        xfer(1'b1, 32'h0000_0FFC, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h0000_0FFC, 32'h0);
        check("unmapped", rd, 32'h0);
        do_reset();
        for (int i = 0; i < 22; i += 2) xfer(1'b1, cfg[i], cfg[i + 1]);
        foreach (rows[i]) vme(rows[i]);
        drain();
        // master enable reads back; status shows last claim by image 0 and a miss
        xfer(1'b0, CSR_OFS, 32'h0);
        check("csr", rd, 32'h0000_0004);
        xfer(1'b0, STAT_OFS, 32'h0);
        check("status", rd, 32'h0001_1000);
        xfer(1'b1, STAT_OFS, 32'h0);
        xfer(1'b0, STAT_OFS, 32'h0);
        check("cleared", rd, 32'h0000_1000);
        // master enable off, then image disabled
        r = rows[0];
        r.c = 1'b0;
        xfer(1'b1, CSR_OFS, 32'h0);
        vme(r);
        xfer(1'b1, CSR_OFS, 32'h0000_0004);
        xfer(1'b1, CTL_OFS[1], 32'h60F2_00C0);
        vme(r);
        xfer(1'b1, CTL_OFS[1], 32'hE0F2_00C0);
        // fill the queue against a stalled target, then drain slowly
        mode <= 2'h2;
        repeat (QDEPTH) vme(rows[0]);
        vme_valid <= 1'b1;
        @(negedge clk);
        check("full", vme_ready, 1'b0);
        mode <= 2'h1;
        vme(rows[0]);
        drain();
        // third reset in mid-run
        do_reset();
        xfer(1'b0, CTL_OFS[1], 32'h0);
        check("rereset", rd, 32'h00F0_00C0);
        end_sim();
    end
endmodule
`default_nettype wire
